// ===== verilog/psl_consts.svh
// Offsets, field positions, reset values and pin indices of the strap latch
`ifndef PSL_CONSTS_SVH
`define PSL_CONSTS_SVH

// Register byte offsets
`define PSL_OFF_CTRL      4'h0
`define PSL_OFF_ADV       4'h4
`define PSL_OFF_STRAP     4'h8

// Control word fields
`define PSL_CTRL_DUPLEX   8
`define PSL_CTRL_ISOLATE  10
`define PSL_CTRL_AUTONEG  12
`define PSL_CTRL_SPEED    13

// Advertisement word fields
`define PSL_ADV_SEL       5'h01
`define PSL_ADV_10HD      5
`define PSL_ADV_10FD      6
`define PSL_ADV_100HD     7
`define PSL_ADV_100FD     8

// Strap status word fields
`define PSL_STAT_ADDR0    0
`define PSL_STAT_TEST     1
`define PSL_STAT_DONE     2

// Strap pin indices
`define PSL_PIN_ISO       0
`define PSL_PIN_SPEED     1
`define PSL_PIN_DUPLEX    2
`define PSL_PIN_AUTONEG   3
`define PSL_PIN_ADDR0     4
`define PSL_PIN_TEST      5
`define PSL_NPIN          6

// Reset values, as if every strap sits at its internal pull
`define PSL_CTRL_RST      16'h3000
`define PSL_ADV_RST       16'h01e1
`define PSL_PIN_PULLS     6'h2e

`endif

// ===== verilog/psl_pkg.sv
// Types shared by the strap latch
`default_nettype none
package psl_pkg;

  // Phase of the strap latch around reset
  typedef enum logic [1:0] {
    PSL_HOLD,
    PSL_RUN
  } psl_phase_t;

  typedef logic [15:0] psl_word_t;

endpackage : psl_pkg

`default_nettype wire

// ===== verilog/psl_strap_latch.sv
// Strap option latch with Avalon-MM register access
`timescale 1ns/10ps
`default_nettype none
`include "psl_consts.svh"

module psl_strap_latch
  import psl_pkg::*;
#(
  parameter int NPIN = `PSL_NPIN
) (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst_b,
  // Avalon-MM slave
  input  wire logic [3:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  input  wire logic [3:0]      avs_byteenable,
  output logic      [31:0]     avs_readdata,
  output logic                 avs_waitrequest,
  // Shared strap pins
  input  wire logic [NPIN-1:0] strap_in,
  output logic      [NPIN-1:0] strap_out,
  output logic      [NPIN-1:0] strap_oe,
  // Functional data driven on the pins after reset
  input  wire logic [NPIN-1:0] pin_fn_data,
  // Latched options
  output logic      [15:0]     ctrl_word,
  output logic      [15:0]     adv_word,
  output logic                 addr0_unique,
  output logic                 pin_test_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and phase tracking

  logic [NPIN-1:0] sync1_reg;
  logic [NPIN-1:0] sync2_reg;
  psl_phase_t      phase_reg;
  logic            capture;
  logic            bus_req;
  logic            bus_acc;
  logic            wr_ctrl;
  logic            wr_adv;
  psl_word_t       ctrl_reg;
  psl_word_t       adv_reg;
  logic            addr0_reg;
  logic            test_reg;
  logic            wait_reg;
  logic [31:0]     rdata_reg;
  logic [31:0]     rdata_next;
  logic [NPIN-1:0] out_reg;
  logic [NPIN-1:0] oe_reg;
  logic [15:0]     be_mask;

  // Two flops on every strap pin before any logic reads it
  always_ff @(posedge clk_sys) begin
    sync1_reg <= strap_in;
    sync2_reg <= sync1_reg;
  end

  // Hold while in reset, run after the first released edge
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      phase_reg <= PSL_HOLD;
    end else begin
      case (phase_reg)
        PSL_HOLD: phase_reg <= PSL_RUN;
        PSL_RUN:  phase_reg <= PSL_RUN;
        default:  phase_reg <= PSL_HOLD;
      endcase
    end
  end

  // Gated by reset so that reset edges never look like a capture edge
  assign capture = rst_b & (phase_reg == PSL_HOLD);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign bus_req = avs_read | avs_write;
  assign bus_acc = bus_req & ~wait_reg;
  assign wr_ctrl = bus_acc & avs_write & (avs_address == `PSL_OFF_CTRL);
  assign wr_adv  = bus_acc & avs_write & (avs_address == `PSL_OFF_ADV);
  assign be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  ////////////////////////////////////////////////////////////////////////////
  // Control word: strap capture, then software owns it

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_reg <= `PSL_CTRL_RST;
    end else if (capture) begin
      ctrl_reg                    <= `PSL_CTRL_RST;
      ctrl_reg[`PSL_CTRL_ISOLATE] <= sync2_reg[`PSL_PIN_ISO];
      ctrl_reg[`PSL_CTRL_SPEED]   <= sync2_reg[`PSL_PIN_SPEED];
      ctrl_reg[`PSL_CTRL_DUPLEX]  <= ~sync2_reg[`PSL_PIN_DUPLEX];
      ctrl_reg[`PSL_CTRL_AUTONEG] <= sync2_reg[`PSL_PIN_AUTONEG];
    end else if (wr_ctrl) begin
      ctrl_reg <= (ctrl_reg & ~be_mask) | (avs_writedata[15:0] & be_mask);
    end
  end

  // Advertisement word follows the rate strap
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      adv_reg <= `PSL_ADV_RST;
    end else if (capture) begin
      adv_reg                   <= `PSL_ADV_RST;
      adv_reg[`PSL_ADV_100HD]   <= sync2_reg[`PSL_PIN_SPEED];
      adv_reg[`PSL_ADV_100FD]   <= sync2_reg[`PSL_PIN_SPEED];
    end else if (wr_adv) begin
      adv_reg <= (adv_reg & ~be_mask) | (avs_writedata[15:0] & be_mask);
    end
  end

  // Internal options, read-only to software
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      addr0_reg <= 1'b0;
      test_reg  <= 1'b0;
    end else if (capture) begin
      addr0_reg <= sync2_reg[`PSL_PIN_ADDR0];
      test_reg  <= ~sync2_reg[`PSL_PIN_TEST];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin direction: inputs in reset, functional outputs afterwards

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      oe_reg  <= '0;
      out_reg <= '0;
    end else begin
      oe_reg  <= {NPIN{phase_reg == PSL_RUN}};
      out_reg <= pin_fn_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM answer: one wait cycle, then data and waitrequest low

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (avs_address)
      `PSL_OFF_CTRL:  rdata_next[15:0] = ctrl_reg;
      `PSL_OFF_ADV:   rdata_next[15:0] = adv_reg;
      `PSL_OFF_STRAP: begin
        rdata_next[`PSL_STAT_ADDR0] = addr0_reg;
        rdata_next[`PSL_STAT_TEST]  = test_reg;
        rdata_next[`PSL_STAT_DONE]  = (phase_reg == PSL_RUN);
      end
      default:        rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= ~(bus_req & wait_reg);
      if (avs_read & wait_reg) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Outputs straight from flops
  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign strap_out       = out_reg;
  assign strap_oe        = oe_reg;
  assign ctrl_word       = ctrl_reg;
  assign adv_word        = adv_reg;
  assign addr0_unique    = addr0_reg;
  assign pin_test_mode   = test_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_release;
    capture ##1 (phase_reg == PSL_RUN);
  endsequence

  a_iso_capture: assert property (
    capture |=> ctrl_reg[`PSL_CTRL_ISOLATE] == $past(sync2_reg[`PSL_PIN_ISO]))
    else $error("isolate bit not captured");
  a_speed_capture: assert property (
    capture |=> ctrl_reg[`PSL_CTRL_SPEED] == $past(sync2_reg[`PSL_PIN_SPEED]))
    else $error("speed bit not captured");
  a_adv_speed: assert property (
    capture |=> adv_reg[`PSL_ADV_100FD:`PSL_ADV_100HD]
                == {2{$past(sync2_reg[`PSL_PIN_SPEED])}})
    else $error("advertisement does not follow rate strap");
  a_duplex_capture: assert property (
    capture |=> ctrl_reg[`PSL_CTRL_DUPLEX] != $past(sync2_reg[`PSL_PIN_DUPLEX]))
    else $error("duplex bit wrong sense");
  a_autoneg_capture: assert property (
    capture |=> ctrl_reg[`PSL_CTRL_AUTONEG] == $past(sync2_reg[`PSL_PIN_AUTONEG]))
    else $error("autoneg bit not captured");
  a_addr0_test: assert property (
    capture |=> (addr0_reg == $past(sync2_reg[`PSL_PIN_ADDR0]))
                && (test_reg != $past(sync2_reg[`PSL_PIN_TEST])))
    else $error("address-0 or test option not captured");
  a_no_recapture: assert property (
    (phase_reg == PSL_RUN) |=> $stable(addr0_reg) && $stable(test_reg))
    else $error("options changed after capture");
  a_pins_output: assert property (
    s_release |=> (oe_reg == {NPIN{1'b1}}))
    else $error("strap pins not turned to outputs");
  a_pins_input: assert property (
    $rose(rst_b) |-> (oe_reg == '0) ##1 (oe_reg == '0))
    else $error("strap pins driven during capture");
  a_reset_defaults: assert property (
    $rose(rst_b) |-> (ctrl_reg == `PSL_CTRL_RST) && (adv_reg == `PSL_ADV_RST)
                     && !addr0_reg && !test_reg)
    else $error("defaults not held through reset");
  a_write_wins: assert property (
    wr_ctrl && (avs_byteenable[1:0] == 2'b11) |=> ctrl_reg == $past(avs_writedata[15:0]))
    else $error("software write lost");
  a_bus_answer: assert property (
    bus_req && wait_reg |=> !wait_reg ##1 wait_reg)
    else $error("bus answer not one cycle");

endmodule : psl_strap_latch

`default_nettype wire

// ===== verification/psl_board.sv
// Board strap resistors and the shared pin wire
`timescale 1ns/10ps
`default_nettype none
module psl_board #(
  parameter int NPIN = 6
) (
  // Board pull levels
  input  wire logic [NPIN-1:0] pull_lvl,
  // Device pin side
  input  wire logic [NPIN-1:0] dev_out,
  input  wire logic [NPIN-1:0] dev_oe,
  output logic      [NPIN-1:0] pin_lvl
);
  // Device wins where it drives, resistors hold the rest
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pin_lvl[i] = dev_oe[i] ? dev_out[i] : pull_lvl[i];
    end
  end
endmodule : psl_board
`default_nettype wire

// ===== verification/psl_bench.sv
// Self-checking bench for the strap option latch
`timescale 1ns/10ps
`default_nettype none
`include "psl_consts.svh"
module phy_strap_option_latch_bench;
  import psl_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_b   = 1'b0;
  logic [3:0]  adr = 4'h0, be = 4'h0;
  logic        rd = 1'b0, wr = 1'b0;
  logic [31:0] wd = 32'h0, rdat, q;
  logic        wt, a0u, tmode;
  logic [5:0]  pin, sout, soe, fn = 6'h00, pull = 6'h3f;
  psl_word_t   ctrl, adv;
  int          n_fail = 0;
  int          total_checks = 0;
  ////////////////////////////////////////////////////////////////////
  // Design and board
  psl_strap_latch i_psl_strap_latch (.clk_sys(clk_sys), .rst_b(rst_b),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wt),
    .strap_in(pin), .strap_out(sout), .strap_oe(soe), .pin_fn_data(fn),
    .ctrl_word(ctrl), .adv_word(adv), .addr0_unique(a0u), .pin_test_mode(tmode));
  psl_board i_psl_board (.pull_lvl(pull), .dev_out(sout), .dev_oe(soe), .pin_lvl(pin));
  // Clock
  always #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Verdict
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // One Avalon transfer, held until waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge clk_sys);
    adr <= a;
    wd  <= d;
    be  <= b;
    wr  <= w;
    rd  <= ~w;
    do @(posedge clk_sys); while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  // Reset with given board levels; levels flip at release
  task automatic do_reset(input logic [5:0] lvl);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    pull  <= lvl;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("rst ctrl", ctrl, 32'h3000);
    check("rst adv", adv, 32'h01e1);
    check("rst opt", {a0u, tmode}, 32'h0);
    check("rst oe", soe, 32'h0);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    pull  <= ~lvl;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////
  // Capture of one strap pattern
  task automatic t_capture(input logic [5:0] lvl, input logic [15:0] ec,
                           input logic [15:0] ea, input logic [2:0] es);
    do_reset(lvl);
    check("ctrl", ctrl, ec);
    check("adv", adv, ea);
    check("addr0", a0u, es[0]);
    check("test", tmode, es[1]);
    check("oe", soe, 32'h3f);
    @(posedge clk_sys);
    fn <= lvl ^ 6'h15;
    bus(1'b0, `PSL_OFF_STRAP, 32'h0, 4'hf);
    check("status", q, {29'h0, es});
    @(negedge clk_sys);
    check("pin out", sout, lvl ^ 6'h15);
    $display("capture %h done", lvl);
  endtask : t_capture
  // Software override, read-only and unmapped places
  task automatic t_soft;
    bus(1'b1, `PSL_OFF_CTRL, 32'hffff_2100, 4'h3);
    bus(1'b0, `PSL_OFF_CTRL, 32'h0, 4'hf);
    check("sw ctrl", q, 32'h2100);
    bus(1'b1, `PSL_OFF_CTRL, 32'h0000_00ff, 4'h2);
    @(negedge clk_sys);
    check("lane ctrl", ctrl, 32'h0000);
    bus(1'b1, `PSL_OFF_STRAP, 32'h0, 4'hf);
    bus(1'b0, `PSL_OFF_STRAP, 32'h0, 4'hf);
    check("ro status", q, 32'h4);
    bus(1'b0, 4'hc, 32'h0, 4'hf);
    check("unmapped", q, 32'h0);
    bus(1'b1, `PSL_OFF_ADV, 32'hffff_0061, 4'h3);
    bus(1'b0, `PSL_OFF_ADV, 32'h0, 4'hf);
    check("sw adv", q, 32'h0061);
    $display("software done");
  endtask : t_soft
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    t_capture(6'h3f, 16'h3400, 16'h01e1, 3'h5);
    t_capture(6'h00, 16'h0100, 16'h0061, 3'h6);
    t_capture(6'h2a, 16'h3100, 16'h01e1, 3'h4);
    t_soft;
    end_of_test;
  end
  // Watchdog
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    end_of_test;
  end
endmodule : phy_strap_option_latch_bench
`default_nettype wire
